// *** core/beic_bit_reg.sv ***
// one word of sticky bits with set and clear vectors
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "beic_regs.svh"
module beic_bit_reg
  import beic_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire beic_word_t set_bits,
  input  wire beic_word_t clr_bits,
  input  wire logic       set_wins,
  output var  beic_word_t value
);
  beic_word_t next_value;

  always_comb begin
    if (set_wins) begin
      next_value = ((value & ~clr_bits) | set_bits) & `BEIC_IMPL_MASK;
    end else begin
      next_value = ((value | set_bits) & ~clr_bits) & `BEIC_IMPL_MASK;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      value <= `BEIC_ENABLE_RESET;
    end else begin
      value <= next_value;
    end
  end
endmodule : beic_bit_reg
`default_nettype wire

// *** core/beic_decode.sv ***
// address decode of the register port
// assumes strobes are one cycle and never both high
`timescale 1ns/1ps
`default_nettype none
`include "beic_regs.svh"
module beic_decode
  import beic_pkg::*;
(
  input  wire logic [7:0] addr,
  input  wire logic       strobe,
  output var  beic_acc_t  acc
);
  always_comb begin
    acc = BEIC_ACC_NONE;
    if (strobe) begin
      unique case (addr)
        `BEIC_OFS_ENABLE_SET: acc = BEIC_ACC_SET;
        `BEIC_OFS_ENABLE_CLR: acc = BEIC_ACC_CLR;
        `BEIC_OFS_STATUS:     acc = BEIC_ACC_STAT;
        default:              acc = BEIC_ACC_NONE;
      endcase
    end
  end
endmodule : beic_decode
`default_nettype wire

// *** core/beic_pkg.sv ***
// types for the back-end interrupt enable clear block
// assumes the constants header is included beside it
`default_nettype none
package beic_pkg;
  typedef logic [31:0] beic_word_t;
  typedef enum logic [1:0] {
    BEIC_ACC_NONE,
    BEIC_ACC_SET,
    BEIC_ACC_CLR,
    BEIC_ACC_STAT
  } beic_acc_t;
endpackage : beic_pkg
`default_nettype wire

// *** core/beic_regs.svh ***
// constants for the back-end interrupt enable clear block
// assumes inclusion by bare name from core/
`ifndef BEIC_REGS_SVH
`define BEIC_REGS_SVH

// ************************************************
// register offsets (byte addresses, one word each)
// ************************************************
`define BEIC_ADDR_W          8
`define BEIC_OFS_ENABLE_SET  8'h00
`define BEIC_OFS_ENABLE_CLR  8'h04
`define BEIC_OFS_STATUS      8'h08

// ************************************************
// field positions
// ************************************************
`define BEIC_BIT_HOST_TO_DSP 31
`define BEIC_BIT_SOFT_HI     27
`define BEIC_BIT_SOFT_LO     24
`define BEIC_BIT_PARITY      6
`define BEIC_BIT_SYSTEM      5
`define BEIC_BIT_MASTER_AB   2
`define BEIC_BIT_TARGET_AB   1

// implemented bits: 31, 27-24, 6, 5, 2, 1
`define BEIC_IMPL_MASK       32'h8F00_0066
`define BEIC_ENABLE_RESET    32'h0000_0000
`define BEIC_STATUS_RESET    32'h0000_0000

`endif

// *** core/beic_top.sv ***
// back-end interrupt enable register with write-one-to-clear port
// assumes a synchronous register master and status events from the core
//
// Summary of operation
// - a one written to bit 31 of the clear register drops the host-to-DSP enable.
// - the DSP line is high while any enable bit and its status bit are both one.
// - dropping the host-to-DSP enable leaves the other sources able to raise the line.
// - ones written to bits 27..24 drop the matching software interrupt enables.
// - a one written to bit 6 drops the parity error enable.
// - a one written to bit 5 drops the system error enable.
// - a one written to bit 2 drops the master abort enable.
// - a one written to bit 1 drops the target abort enable.
// - zeros written to the clear register leave enables as they are.
// - reading the clear register returns status AND enable.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "beic_regs.svh"
module beic_top
  import beic_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic        host_to_dsp_irq,
  input  wire logic [3:0]  soft_irq,
  input  wire logic        parity_error_detect,
  input  wire logic        system_error_detect,
  input  wire logic        master_abort_detect,
  input  wire logic        target_abort_detect,
  output var  logic [31:0] rdata,
  output var  logic        dsp_irq
);
  // ************************************************
  // decode
  // ************************************************
  beic_acc_t  wr_acc;
  beic_acc_t  rd_acc;
  beic_word_t enable;
  beic_word_t status;
  beic_word_t ev_bits;
  beic_word_t en_set;
  beic_word_t en_clr;
  beic_word_t st_clr;
  beic_word_t next_rdata;
  logic       next_dsp_irq;

  beic_decode u_wdec (
    .addr   (addr),
    .strobe (wr),
    .acc    (wr_acc)
  );
  beic_decode u_rdec (
    .addr   (addr),
    .strobe (rd),
    .acc    (rd_acc)
  );

  // ************************************************
  // enable and status words
  // ************************************************
  always_comb begin
    ev_bits = '0;
    ev_bits[`BEIC_BIT_HOST_TO_DSP] = host_to_dsp_irq;
    ev_bits[`BEIC_BIT_SOFT_HI:`BEIC_BIT_SOFT_LO] = soft_irq;
    ev_bits[`BEIC_BIT_PARITY] = parity_error_detect;
    ev_bits[`BEIC_BIT_SYSTEM] = system_error_detect;
    ev_bits[`BEIC_BIT_MASTER_AB] = master_abort_detect;
    ev_bits[`BEIC_BIT_TARGET_AB] = target_abort_detect;
    en_set = (wr_acc == BEIC_ACC_SET) ? wdata : '0;
    // only ones clear; reserved bits masked in the register
    en_clr = (wr_acc == BEIC_ACC_CLR) ? wdata : '0;
    st_clr = (wr_acc == BEIC_ACC_STAT) ? wdata : '0;
  end

  // enables: software owns both set and clear, clear is the later word
  beic_bit_reg u_enable (
    .clk      (clk),
    .nrst     (nrst),
    .set_bits (en_set),
    .clr_bits (en_clr),
    .set_wins (1'b0),
    .value    (enable)
  );
  // status: a hardware event beats a software clear in the same cycle
  beic_bit_reg u_status (
    .clk      (clk),
    .nrst     (nrst),
    .set_bits (ev_bits),
    .clr_bits (st_clr),
    .set_wins (1'b1),
    .value    (status)
  );

  // ************************************************
  // read data and interrupt line
  // ************************************************
  always_comb begin
    next_rdata = '0;
    unique case (rd_acc)
      BEIC_ACC_SET:  next_rdata = enable;
      BEIC_ACC_CLR:  next_rdata = status & enable & `BEIC_IMPL_MASK;
      BEIC_ACC_STAT: next_rdata = status;
      BEIC_ACC_NONE: next_rdata = '0;
    endcase
    // all sources share the line, so one dropped enable removes only its own source from it
    next_dsp_irq = |(status & enable);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata   <= '0;
      dsp_irq <= 1'b0;
    end else begin
      rdata   <= next_rdata;
      dsp_irq <= next_dsp_irq;
    end
  end

  // ************************************************
  // checks
  // ************************************************
  a_clear_host_bit: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `BEIC_OFS_ENABLE_CLR && wdata[31]) |=> !enable[31])
    else $error("host enable not cleared");
  a_clear_soft_bits: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `BEIC_OFS_ENABLE_CLR) |=> ((enable[27:24] & $past(wdata[27:24])) == 4'h0))
    else $error("soft enable not cleared");
  a_clear_err_bits: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `BEIC_OFS_ENABLE_CLR && wdata[6]) |=> !enable[6])
    else $error("parity enable not cleared");
  a_clear_sys_bit: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `BEIC_OFS_ENABLE_CLR && wdata[5]) |=> !enable[5])
    else $error("system enable not cleared");
  a_clear_mabort_bit: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `BEIC_OFS_ENABLE_CLR && wdata[2]) |=> !enable[2])
    else $error("master abort enable not cleared");
  a_clear_tabort_bit: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `BEIC_OFS_ENABLE_CLR && wdata[1]) |=> !enable[1])
    else $error("target abort enable not cleared");
  a_zero_keeps_enable: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `BEIC_OFS_ENABLE_CLR) |=> ((enable & ~$past(wdata)) == ($past(enable) & ~$past(wdata))))
    else $error("zero write changed enable");
  a_irq_follows_src: assert property (@(posedge clk) disable iff (!nrst)
    ##1 dsp_irq == |($past(status) & $past(enable)))
    else $error("dsp line mismatch");
  a_irq_other_src: assert property (@(posedge clk) disable iff (!nrst)
    (!enable[31] && |(status[30:0] & enable[30:0])) |=> dsp_irq)
    else $error("line gated by host enable");
  a_read_masked: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == `BEIC_OFS_ENABLE_CLR) |=> rdata == ($past(status) & $past(enable)))
    else $error("masked read wrong");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
    ((rdata | enable) & ~`BEIC_IMPL_MASK) == 32'h0000_0000)
    else $error("reserved bit set");

  // ************************************************
  // checks: register port
  // ************************************************
  // read data must fall back to zero so software never sees a stale word
  a_rdata_idle: assert property (@(posedge clk) disable iff (!nrst)
    !rd
    |=> rdata == 32'h0000_0000)
    else $error("read data outside a read");
  a_read_enable: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == `BEIC_OFS_ENABLE_SET)
    |=> rdata == $past(enable))
    else $error("enable read wrong");
  a_read_status: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == `BEIC_OFS_STATUS)
    |=> rdata == $past(status))
    else $error("status read wrong");
  a_read_unmapped: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr != `BEIC_OFS_ENABLE_SET && addr != `BEIC_OFS_ENABLE_CLR
      && addr != `BEIC_OFS_STATUS)
    |=> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // ************************************************
  // checks: enable word
  // ************************************************
  a_set_enable_bits: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `BEIC_OFS_ENABLE_SET)
    |=> enable == (($past(enable) | $past(wdata)) & `BEIC_IMPL_MASK))
    else $error("enable set wrong");
  a_clear_word_exact: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `BEIC_OFS_ENABLE_CLR)
    |=> enable == ($past(enable) & ~$past(wdata) & `BEIC_IMPL_MASK))
    else $error("enable clear wrong");
  a_keep_host_bit: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `BEIC_OFS_ENABLE_CLR && !wdata[31])
    |=> enable[31] == $past(enable[31]))
    else $error("host enable lost on zero write");
  a_enable_holds: assert property (@(posedge clk) disable iff (!nrst)
    !(wr && (addr == `BEIC_OFS_ENABLE_SET || addr == `BEIC_OFS_ENABLE_CLR))
    |=> $stable(enable))
    else $error("enable moved without a write");

  // ************************************************
  // checks: status word
  // ************************************************
  a_status_sticky: assert property (@(posedge clk) disable iff (!nrst)
    !(wr && addr == `BEIC_OFS_STATUS)
    |=> ($past(status) & ~status) == 32'h0000_0000)
    else $error("status bit fell without a clear");
  // a clear never beats an event arriving in the same cycle
  a_status_clear: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == `BEIC_OFS_STATUS)
    |=> (status & $past(wdata) & ~$past(ev_bits)) == 32'h0000_0000)
    else $error("status bit not cleared");
  a_status_reserved: assert property (@(posedge clk) disable iff (!nrst)
    (status & ~`BEIC_IMPL_MASK) == 32'h0000_0000)
    else $error("reserved status bit set");
  a_host_event_sets: assert property (@(posedge clk) disable iff (!nrst)
    host_to_dsp_irq
    |=> status[`BEIC_BIT_HOST_TO_DSP])
    else $error("host event lost");
  a_soft_event_sets: assert property (@(posedge clk) disable iff (!nrst)
    (|soft_irq)
    |=> ((status[`BEIC_BIT_SOFT_HI:`BEIC_BIT_SOFT_LO] & $past(soft_irq)) == $past(soft_irq)))
    else $error("software event lost");
  a_parity_event_sets: assert property (@(posedge clk) disable iff (!nrst)
    parity_error_detect
    |=> status[`BEIC_BIT_PARITY])
    else $error("parity event lost");
  a_system_event_sets: assert property (@(posedge clk) disable iff (!nrst)
    system_error_detect
    |=> status[`BEIC_BIT_SYSTEM])
    else $error("system event lost");
  a_mabort_event_sets: assert property (@(posedge clk) disable iff (!nrst)
    master_abort_detect
    |=> status[`BEIC_BIT_MASTER_AB])
    else $error("master abort event lost");
  a_tabort_event_sets: assert property (@(posedge clk) disable iff (!nrst)
    target_abort_detect
    |=> status[`BEIC_BIT_TARGET_AB])
    else $error("target abort event lost");

  // ************************************************
  // checks: interrupt line
  // ************************************************
  // every source must reach the line through its own enable; the host enable gates only the host source
  a_src_host_irq: assert property (@(posedge clk) disable iff (!nrst)
    (status[`BEIC_BIT_HOST_TO_DSP] && enable[`BEIC_BIT_HOST_TO_DSP])
    |=> dsp_irq)
    else $error("host source did not raise line");
  a_src_soft_irq: assert property (@(posedge clk) disable iff (!nrst)
    (|(status[`BEIC_BIT_SOFT_HI:`BEIC_BIT_SOFT_LO]
       & enable[`BEIC_BIT_SOFT_HI:`BEIC_BIT_SOFT_LO]))
    |=> dsp_irq)
    else $error("software source did not raise line");
  a_src_parity_irq: assert property (@(posedge clk) disable iff (!nrst)
    (status[`BEIC_BIT_PARITY] && enable[`BEIC_BIT_PARITY])
    |=> dsp_irq)
    else $error("parity source did not raise line");
  a_src_system_irq: assert property (@(posedge clk) disable iff (!nrst)
    (status[`BEIC_BIT_SYSTEM] && enable[`BEIC_BIT_SYSTEM])
    |=> dsp_irq)
    else $error("system source did not raise line");
  a_src_mabort_irq: assert property (@(posedge clk) disable iff (!nrst)
    (status[`BEIC_BIT_MASTER_AB] && enable[`BEIC_BIT_MASTER_AB])
    |=> dsp_irq)
    else $error("master abort source did not raise line");
  a_src_tabort_irq: assert property (@(posedge clk) disable iff (!nrst)
    (status[`BEIC_BIT_TARGET_AB] && enable[`BEIC_BIT_TARGET_AB])
    |=> dsp_irq)
    else $error("target abort source did not raise line");
  a_irq_quiet: assert property (@(posedge clk) disable iff (!nrst)
    ((status & enable) == 32'h0000_0000)
    |=> !dsp_irq)
    else $error("line high with no source");

  // ************************************************
  // checks: reset values
  // ************************************************
  // low for exactly one cycle after any reset, so the reset values are visible
  logic       out_of_reset;
  logic       next_out_of_reset;

  always_comb begin
    next_out_of_reset = 1'b1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_of_reset <= 1'b0;
    end else begin
      out_of_reset <= next_out_of_reset;
    end
  end

  a_reset_clears_words: assert property (@(posedge clk) disable iff (!nrst)
    !out_of_reset
    |-> (enable == `BEIC_ENABLE_RESET && status == `BEIC_STATUS_RESET))
    else $error("words not cleared by reset");
  a_reset_quiet_outputs: assert property (@(posedge clk) disable iff (!nrst)
    !out_of_reset
    |-> (rdata == 32'h0000_0000 && !dsp_irq))
    else $error("outputs not quiet after reset");
endmodule : beic_top
`default_nettype wire

// *** testbench/beic_dsp_model.sv ***
// far side: the core and software raising the status events
// assumes one clock; the block samples events as levels
`timescale 1ns/1ps
`default_nettype none
module beic_dsp_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [31:0] fire,
  output var  logic        host_ev,
  output var  logic [3:0]  soft_ev,
  output var  logic [3:0]  err_ev
);
  // one-cycle pulses only: status must hold them by itself
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      host_ev <= 1'b0;
      soft_ev <= 4'h0;
      err_ev  <= 4'h0;
    end else begin
      host_ev <= fire[31];
      soft_ev <= fire[27:24];
      err_ev  <= {fire[6], fire[5], fire[2], fire[1]};
    end
  end
endmodule : beic_dsp_model
`default_nettype wire

// *** testbench/beic_top_tb.sv ***
// self-checking bench for the enable clear register
// assumes the design carries its own assertions
`timescale 1ns/1ps
`default_nettype none
`include "beic_regs.svh"
module beic_top_tb
  import beic_pkg::*;
();
  logic       clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, rd_seen = 1'b0;
  logic [7:0] addr = 8'h00;
  beic_word_t wdata = 32'h0, fire = 32'h0, rdata, en, lf = 32'h882ED022;
  logic       dsp_irq, host_ev;
  logic [3:0] soft_ev, err_ev;
  beic_word_t exp_q[$];
  int         mismatches = 0, cmp_count = 0;
  int         bits[8] = '{27, 26, 25, 24, 6, 5, 2, 1};
  int         srcs[9] = '{31, 27, 26, 25, 24, 6, 5, 2, 1};

  beic_top dut_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .host_to_dsp_irq(host_ev), .soft_irq(soft_ev), .parity_error_detect(err_ev[3]),
    .system_error_detect(err_ev[2]), .master_abort_detect(err_ev[1]),
    .target_abort_detect(err_ev[0]), .rdata(rdata), .dsp_irq(dsp_irq));
  beic_dsp_model far_u (.clk(clk), .nrst(nrst), .fire(fire), .host_ev(host_ev),
    .soft_ev(soft_ev), .err_ev(err_ev));

  always #5 clk = ~clk;

  // ****************
  // tasks
  // ****************
  function automatic beic_word_t lfsr(input beic_word_t s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input beic_word_t got, input beic_word_t want);
    cmp_count++;
    if (got !== want) begin
      mismatches++;
      $display("wrong value at %0t: read %h, expected %h", $time, got, want);
    end
  endtask : chk
  task automatic chk_irq(input logic want);
    cmp_count++;
    if (dsp_irq !== want) begin
      mismatches++;
      $display("wrong value at %0t: interrupt line %b", $time, dsp_irq);
    end
  endtask : chk_irq
  task automatic wr_reg(input logic [7:0] a, input beic_word_t d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input beic_word_t want);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(want);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen) chk(rdata, exp_q.pop_front());
    rd_seen = rd;
  end

  initial begin
    #20000;
    mismatches++;
    complete_run();
  end

  // ****************
  // sequence
  // ****************
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    wr_reg(`BEIC_OFS_ENABLE_SET, 32'hFFFF_FFFF);
    rd_reg(`BEIC_OFS_ENABLE_SET, `BEIC_IMPL_MASK);
    @(posedge clk);
    fire <= 32'hFFFF_FFFF;
    @(posedge clk);
    fire <= 32'h0;
    repeat (3) @(posedge clk);
    #1 chk_irq(1'b1);
    rd_reg(`BEIC_OFS_ENABLE_CLR, `BEIC_IMPL_MASK);
    wr_reg(`BEIC_OFS_ENABLE_CLR, 32'h0);
    rd_reg(`BEIC_OFS_ENABLE_CLR, `BEIC_IMPL_MASK);
    wr_reg(`BEIC_OFS_ENABLE_CLR, 32'h8000_0000);
    rd_reg(`BEIC_OFS_ENABLE_CLR, 32'h0F00_0066);
    #1 chk_irq(1'b1);
    $display("test basic done");
    foreach (bits[i]) begin
      wr_reg(`BEIC_OFS_ENABLE_SET, `BEIC_IMPL_MASK);
      wr_reg(`BEIC_OFS_ENABLE_CLR, 32'h1 << bits[i]);
      rd_reg(`BEIC_OFS_ENABLE_CLR, `BEIC_IMPL_MASK & ~(32'h1 << bits[i]));
    end
    $display("test single bits done");
    en = `BEIC_IMPL_MASK;
    wr_reg(`BEIC_OFS_ENABLE_SET, en);
    repeat (6) begin
      lf = lfsr(lf);
      wr_reg(`BEIC_OFS_ENABLE_CLR, lf);
      en = en & ~lf;
      rd_reg(`BEIC_OFS_ENABLE_CLR, en);
    end
    wr_reg(`BEIC_OFS_ENABLE_CLR, 32'hFFFF_FFFF);
    rd_reg(8'h0C, 32'h0);
    rd_reg(`BEIC_OFS_ENABLE_CLR, 32'h0);
    #1 chk_irq(1'b0);
    $display("test random done");
    wr_reg(`BEIC_OFS_ENABLE_SET, 32'hFFFF_FFFF);
    foreach (srcs[i]) begin
      wr_reg(`BEIC_OFS_STATUS, 32'hFFFF_FFFF);
      @(posedge clk);
      fire <= 32'h1 << srcs[i];
      #1 chk_irq(1'b0);
      @(posedge clk);
      fire <= 32'h0;
      repeat (3) @(posedge clk);
      #1 chk_irq(1'b1);
      rd_reg(`BEIC_OFS_STATUS, 32'h1 << srcs[i]);
      rd_reg(`BEIC_OFS_ENABLE_CLR, 32'h1 << srcs[i]);
    end
    // an event in the cycle of a status clear must survive it
    fork
      wr_reg(`BEIC_OFS_STATUS, 32'hFFFF_FFFF);
      begin
        fire <= 32'h8000_0000;
        @(posedge clk);
        fire <= 32'h0;
      end
    join
    rd_reg(`BEIC_OFS_STATUS, 32'h8000_0000);
    $display("test status done");
    repeat (2) @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1 chk_irq(1'b0);
    rd_reg(`BEIC_OFS_ENABLE_SET, `BEIC_ENABLE_RESET);
    rd_reg(`BEIC_OFS_STATUS, `BEIC_STATUS_RESET);
    $display("test reset done");
    repeat (2) @(posedge clk);
    complete_run();
  end
endmodule : beic_top_tb
`default_nettype wire
